// ===== design/ccp_core.v
// Core special-function logic: timer/watchdog configuration, oscillator
// trim with divided-clock pin output, and program counter update.
// Assumes clock_i is the oscillator and all inputs are synchronous to it;
// instruction inputs are acted on at the clock edge where cycle_o rises.
//
// Functional notes
// - Config register is 8 bits, write-only, loaded whole from W by its instruction.
// - Any reset sets every config bit to one.
// - Output direction disables wake-on-change and pull-up for that pin.
// - Timer clock select high forces the external timer clock pin to input unless osc/4 or comparator output drives it.
// - Bit 7 low enables wake-on-change, bit 6 low enables pull-ups.
// - Bit 5 selects external pin transitions or instruction cycle clock.
// - Bit 3 gives the shared prescaler to timer or watchdog; other undivided.
// - Trim upper seven bits are a signed oscillator adjustment.
// - Trim bit 0 drives oscillator/4 onto general pin two over all else.
// - Program counter holds next address, increments each cycle unless changed.
// - Absolute jump loads all nine counter bits from the instruction.
// - Counter low-byte register maps onto counter bits 7 to 0.
// - Call and low-byte writes load bits 7 to 0 and clear bit 8.
// - Move, add and bit-set to low byte all use the bit-8-clearing load.
// - Reset points the counter at the last location; next step wraps to 0.
`timescale 1ns/100ps
`include "ccp_regs.vh"
module ccp_core (
   input  wire       clock_i,
   input  wire       reset_n_i,
   // Instruction side
   input  wire [7:0] w_data_i,
   input  wire       config_load_i,
   input  wire       trim_we_i,
   input  wire [7:0] trim_wdata_i,
   input  wire       jump_i,
   input  wire [8:0] jump_addr_i,
   input  wire       call_i,
   input  wire [7:0] call_addr_i,
   input  wire       low_byte_we_i,
   input  wire [7:0] low_byte_wdata_i,
   output reg        cycle_o,
   output reg  [8:0] pc_o,
   output reg  [7:0] low_byte_rdata_o,
   output reg  [7:0] trim_rdata_o,
   output reg  [6:0] osc_trim_o,
   // Pin side
   input  wire [2:0] direction_i,
   input  wire [2:0] pin_latch_i,
   input  wire       comparator_out_en_i,
   input  wire       comparator_output_i,
   input  wire       general_pin_two_i,
   input  wire       watchdog_base_i,
   output reg        general_pin_two_o,
   output reg        general_pin_two_oe_o,
   output reg  [2:0] wake_enable_o,
   output reg  [2:0] pullup_enable_o,
   output reg        timer_inc_o,
   output reg        watchdog_inc_o,
   output reg  [7:0] config_o
);
   reg  [1:0] cyc_cnt_r;
   reg        osc_div4_r;
   reg  [7:0] config_r;
   reg  [7:0] trim_r;
   reg  [8:0] pc_r;
   reg  [8:0] pc_nxt;
   reg        pin_prev_r;
   reg        cycle_r;
   reg        gp2_nxt;
   reg        gp2_oe_nxt;

   wire       wake_dis;
   wire       pullup_dis;
   wire       clk_sel;
   wire       edge_sel;
   wire       pre_assign;
   wire [2:0] rate;
   wire       div4_en;
   wire       pin_rise;
   wire       pin_fall;
   reg        pin_edge;
   reg        timer_src;
   reg        pre_in;
   reg  [3:0] pre_exp;
   wire       pre_fire;
   reg        timer_tick;
   reg        wdt_tick;

   assign wake_dis   = config_r[`CCP_CFG_WAKE_DIS];
   assign pullup_dis = config_r[`CCP_CFG_PULLUP_DIS];
   assign clk_sel    = config_r[`CCP_CFG_CLK_SEL];
   assign edge_sel   = config_r[`CCP_CFG_EDGE_SEL];
   assign pre_assign = config_r[`CCP_CFG_PRE_ASSIGN];
   assign rate       = config_r[`CCP_CFG_RATE_HI:`CCP_CFG_RATE_LO];
   assign div4_en    = trim_r[`CCP_TRIM_DIV4_EN];

   // Instruction cycle divider: cycle_r is the one-clock strobe per cycle
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cyc_cnt_r <= 2'h0;
         cycle_r   <= 1'b0;
      end else begin
         cyc_cnt_r <= cyc_cnt_r + 2'h1;
         cycle_r   <= (cyc_cnt_r == `CCP_CYC_DIV);
      end
   end

   // Oscillator/4 waveform: toggles every second clock, a period of four
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_div4_r <= 1'b0;
      end else if (cyc_cnt_r[0]) begin
         osc_div4_r <= ~osc_div4_r;
      end
   end

   // Configuration register; no read path exists
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         config_r <= `CCP_CFG_RESET;
      end else if (cycle_r && config_load_i) begin
         config_r <= w_data_i;
      end
   end

   // Oscillator trim register
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trim_r <= `CCP_TRIM_RESET;
      end else if (cycle_r && trim_we_i) begin
         trim_r <= trim_wdata_i;
      end
   end

   // Program counter source select: jump beats call beats low-byte write
   localparam [1:0] PC_SEL_STEP = 2'h0;
   localparam [1:0] PC_SEL_JUMP = 2'h1;
   localparam [1:0] PC_SEL_CALL = 2'h2;
   localparam [1:0] PC_SEL_LOW  = 2'h3;

   reg  [1:0] pc_sel;

   always @* begin
      pc_sel = PC_SEL_STEP;
      if (jump_i) begin
         pc_sel = PC_SEL_JUMP;
      end else if (call_i) begin
         pc_sel = PC_SEL_CALL;
      end else if (low_byte_we_i) begin
         pc_sel = PC_SEL_LOW;
      end
   end

   // Call and low-byte loads reach only the first 256 locations
   always @* begin
      case (pc_sel)
         PC_SEL_STEP: begin
            pc_nxt = pc_r + `CCP_PC_STEP;
         end
         PC_SEL_JUMP: begin
            pc_nxt = jump_addr_i;
         end
         PC_SEL_CALL: begin
            pc_nxt = {1'b0, call_addr_i};
         end
         PC_SEL_LOW: begin
            pc_nxt = {1'b0, low_byte_wdata_i};
         end
         default: begin
            pc_nxt = pc_r + `CCP_PC_STEP;
         end
      endcase
   end

   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pc_r <= `CCP_PC_RESET;
      end else if (cycle_r) begin
         pc_r <= pc_nxt;
      end
   end

   // External timer clock edges; pin input is already synchronous
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_prev_r <= 1'b0;
      end else begin
         pin_prev_r <= general_pin_two_i;
      end
   end

   assign pin_rise = general_pin_two_i & ~pin_prev_r;
   assign pin_fall = ~general_pin_two_i & pin_prev_r;

   // One prescaler, shared; the unit that does not own it sees its source
   // directly, so it runs undivided
   always @* begin
      pin_edge = pin_rise;
      if (edge_sel) begin
         pin_edge = pin_fall;
      end
      timer_src = cycle_r;
      if (clk_sel) begin
         timer_src = pin_edge;
      end
      if (pre_assign) begin
         pre_in     = watchdog_base_i;
         pre_exp    = {1'b0, rate};
         timer_tick = timer_src;
         wdt_tick   = pre_fire;
      end else begin
         pre_in     = timer_src;
         pre_exp    = {1'b0, rate} + 4'h1;
         timer_tick = pre_fire;
         wdt_tick   = watchdog_base_i;
      end
   end

   // Cleared on each configuration load so a new ratio starts cleanly
   ccp_prescaler u_prescaler (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .clear_i   (cycle_r & config_load_i),
      .tick_i    (pre_in),
      .exp_i     (pre_exp),
      .fire_o    (pre_fire)
   );

   // General pin two precedence: osc/4, comparator, timer input, direction
   always @* begin
      gp2_nxt    = pin_latch_i[2];
      gp2_oe_nxt = ~direction_i[2];
      if (div4_en) begin
         gp2_nxt    = osc_div4_r;
         gp2_oe_nxt = 1'b1;
      end else if (comparator_out_en_i) begin
         gp2_nxt    = comparator_output_i;
         gp2_oe_nxt = 1'b1;
      end else if (clk_sel) begin
         gp2_oe_nxt = 1'b0;
      end
   end

   // Instruction-side readbacks, one clock behind the registers they copy
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cycle_o          <= 1'b0;
         pc_o             <= `CCP_PC_RESET;
         low_byte_rdata_o <= 8'h00;
      end else begin
         cycle_o          <= cycle_r;
         pc_o             <= pc_r;
         low_byte_rdata_o <= pc_r[7:0];
      end
   end

   // Trim readback; the signed trim goes on untouched to the oscillator
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trim_rdata_o <= `CCP_TRIM_RESET;
         osc_trim_o   <= 7'h00;
      end else begin
         trim_rdata_o <= trim_r;
         osc_trim_o   <= trim_r[`CCP_TRIM_CAL_HI:`CCP_TRIM_CAL_LO];
      end
   end

   // Pin two drive, registered so the pad sees no decode glitches
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         general_pin_two_o    <= 1'b0;
         general_pin_two_oe_o <= 1'b0;
      end else begin
         general_pin_two_o    <= gp2_nxt;
         general_pin_two_oe_o <= gp2_oe_nxt;
      end
   end

   // Bits: 0 = pin zero, 1 = pin one, 2 = input-only pin three. Pin three
   // has no direction bit, so only the configuration gates it.
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wake_enable_o   <= 3'h0;
         pullup_enable_o <= 3'h0;
      end else begin
         wake_enable_o[0]   <= ~wake_dis & direction_i[0];
         wake_enable_o[1]   <= ~wake_dis & direction_i[1];
         wake_enable_o[2]   <= ~wake_dis;
         pullup_enable_o[0] <= ~pullup_dis & direction_i[0];
         pullup_enable_o[1] <= ~pullup_dis & direction_i[1];
         pullup_enable_o[2] <= ~pullup_dis;
      end
   end

   // Timer and watchdog increments, and the internal view of the config
   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer_inc_o    <= 1'b0;
         watchdog_inc_o <= 1'b0;
         config_o       <= `CCP_CFG_RESET;
      end else begin
         timer_inc_o    <= timer_tick;
         watchdog_inc_o <= wdt_tick;
         config_o       <= config_r;
      end
   end
endmodule // ccp_core

// ===== design/ccp_prescaler.v
// Shared prescaler: divides an input tick stream by two to the power exp_i.
// Assumes tick_i is a one-cycle pulse on clock_i and clear_i is synchronous.
`timescale 1ns/100ps
module ccp_prescaler (
   input  wire       clock_i,
   input  wire       reset_n_i,
   input  wire       clear_i,
   input  wire       tick_i,
   input  wire [3:0] exp_i,
   output wire       fire_o
);
   reg  [7:0] count_r;
   wire [8:0] full_mask;
   wire [7:0] mask;

   assign full_mask = (9'h001 << exp_i) - 9'h001;
   assign mask      = full_mask[7:0];
   // Exponent zero gives a mask of zero, so every tick passes undivided
   assign fire_o    = tick_i & ((count_r & mask) == mask);

   always @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_r <= 8'h00;
      end else if (clear_i) begin
         count_r <= 8'h00;
      end else if (tick_i) begin
         count_r <= count_r + 8'h01;
      end
   end
endmodule // ccp_prescaler

// ===== design/ccp_regs.vh
// Constants for the core configuration and program counter block.
// Assumes inclusion by bare name from the design files only.
`ifndef CCP_REGS_VH
`define CCP_REGS_VH

// Timer and watchdog configuration fields
`define CCP_CFG_WAKE_DIS      7
`define CCP_CFG_PULLUP_DIS    6
`define CCP_CFG_CLK_SEL       5
`define CCP_CFG_EDGE_SEL      4
`define CCP_CFG_PRE_ASSIGN    3
`define CCP_CFG_RATE_HI       2
`define CCP_CFG_RATE_LO       0
`define CCP_CFG_RESET         8'hff

// Oscillator trim fields
`define CCP_TRIM_CAL_HI       7
`define CCP_TRIM_CAL_LO       1
`define CCP_TRIM_DIV4_EN      0
`define CCP_TRIM_RESET        8'h80

// Program counter
`define CCP_PC_WIDTH          9
`define CCP_PC_RESET          9'h1ff
`define CCP_PC_STEP           9'h001

// Instruction cycle is the oscillator divided by four
`define CCP_CYC_DIV           2'h3

`endif

// ===== dv/ccp_core_props.sv
// Checker on ccp_core ports: instruction timing and pin gating.
// Assumes it is bound to ccp_core.
`timescale 1ns/100ps
module ccp_core_props (
   input wire       clock_i,
   input wire       reset_n_i,
   input wire       cycle_o,
   input wire [8:0] pc_o,
   input wire [7:0] low_byte_rdata_o,
   input wire       jump_i,
   input wire [8:0] jump_addr_i,
   input wire       call_i,
   input wire [7:0] call_addr_i,
   input wire       low_byte_we_i,
   input wire [7:0] low_byte_wdata_i,
   input wire       config_load_i,
   input wire [7:0] w_data_i,
   input wire [7:0] config_o,
   input wire [2:0] direction_i,
   input wire [2:0] wake_enable_o,
   input wire [2:0] pullup_enable_o
);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   // Requests are sampled at the edge where cycle_o rises, so $past sees them
   chk_cycle_gap: assert property ($rose(cycle_o) |=> !cycle_o [*3] ##1 cycle_o)
      else $error("cycle spacing");
   chk_pc_hold: assert property ($changed(pc_o) |-> $past(cycle_o))
      else $error("pc moved off cycle");
   chk_pc_step: assert property (cycle_o && !$past(jump_i) && !$past(call_i)
      && !$past(low_byte_we_i) |=> pc_o == $past(pc_o) + 9'h001) else $error("pc step");
   chk_jump_load: assert property (cycle_o && $past(jump_i)
      |=> pc_o == $past(jump_addr_i, 2)) else $error("jump target");
   chk_call_load: assert property (cycle_o && !$past(jump_i) && $past(call_i)
      |=> pc_o == {1'b0, $past(call_addr_i, 2)}) else $error("call target");
   chk_low_write: assert property (cycle_o && !$past(jump_i) && !$past(call_i)
      && $past(low_byte_we_i) |=> pc_o == {1'b0, $past(low_byte_wdata_i, 2)})
      else $error("low byte write");
   chk_low_map: assert property (cycle_o |-> low_byte_rdata_o == pc_o[7:0])
      else $error("low byte map");
   chk_cfg_load: assert property (cycle_o && $past(config_load_i)
      |=> config_o == $past(w_data_i, 2)) else $error("config load");
   chk_dir_gate: assert property (((wake_enable_o | pullup_enable_o)
      & ~$past(direction_i) & 3'b011) == 3'b000) else $error("output pin gating");
   cover property (cycle_o && $past(call_i));
   cover property (cycle_o && $past(low_byte_we_i));
   cover property (cycle_o && $past(config_load_i));
endmodule // ccp_core_props

bind ccp_core ccp_core_props i_props (.*);

// ===== dv/ccp_core_tb_top.sv
// Self-checking bench for ccp_core.
// Assumes one 200 MHz clock; comparator routing is left off.
`timescale 1ns/100ps
module ccp_core_tb_top;
   logic       clock_i, reset_n_i, config_load_i, trim_we_i, jump_i, call_i, cycle_o;
   logic       low_byte_we_i, general_pin_two_i, watchdog_base_i, general_pin_two_o;
   logic       general_pin_two_oe_o, timer_inc_o, watchdog_inc_o;
   logic [7:0] w_data_i, trim_wdata_i, call_addr_i, low_byte_wdata_i;
   logic [7:0] low_byte_rdata_o, trim_rdata_o, config_o;
   logic [8:0] jump_addr_i, pc_o;
   logic [6:0] osc_trim_o;
   logic [2:0] direction_i, pin_latch_i, wake_enable_o, pullup_enable_o;
   int         miscompares = 0;
   int         tests_run = 0;

   ccp_core i_dut (.comparator_out_en_i(1'b0), .comparator_output_i(1'b0), .*);

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Kinds: 0 none, 1 jump, 2 call, 3 low-byte write, 4 config load, 5 trim write
   task automatic drive(input int k, input logic [8:0] v);
      {jump_i, call_i, low_byte_we_i, config_load_i, trim_we_i} <=
         (k == 0) ? 5'h00 : 5'h10 >> (k - 1);
      {jump_addr_i, call_addr_i, low_byte_wdata_i, w_data_i, trim_wdata_i} <= {v, {4{v[7:0]}}};
   endtask

   // Requests stay up across exactly one action edge, then drop
   task automatic issue(input int k, input logic [8:0] v);
      int         n = 0;
      logic [8:0] pre;
      @(posedge clock_i);
      drive(k, v);
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (cycle_o !== 1'b1 && n < 9);
      pre = pc_o;
      @(posedge clock_i);
      #1;
      pre = (k == 1) ? v : (k == 2 || k == 3) ? {1'b0, v[7:0]} : pre + 9'h001;
      check(pc_o, pre);
      check({1'b0, low_byte_rdata_o}, {1'b0, pre[7:0]});
      if (k == 4)
         check({1'b0, config_o}, v);
      if (k == 5) begin
         check({1'b0, trim_rdata_o}, v);
         check({2'b00, osc_trim_o}, {2'b00, v[7:1]});
      end
      @(posedge clock_i);
      drive(0, v);
   endtask

   // Window of 4n+4 clocks: n pin pulses and n watchdog base ticks
   task automatic run(input int n, input logic [8:0] exp_t, input logic [8:0] exp_w);
      logic [8:0] t = 9'h000;
      logic [8:0] w = 9'h000;
      for (int i = 0; i < 4 * n + 4; i++) begin
         @(posedge clock_i);
         general_pin_two_i <= (i < 4 * n) && (i % 4 >= 2);
         watchdog_base_i <= (i < 4 * n) && (i % 4 == 0);
         #1;
         t = t + timer_inc_o;
         w = w + watchdog_inc_o;
      end
      check(t, exp_t);
      check(w, exp_w);
   endtask

   task automatic do_reset();
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      check({1'b0, config_o}, 9'h0ff);
      check(pc_o, 9'h1ff);
      reset_n_i <= 1'b1;
   endtask

   task automatic t_flow();
      issue(0, 9'h000);
      issue(1, 9'h1fe);
      issue(0, 9'h000);
      issue(0, 9'h000);
      issue(2, 9'h1a5);
      issue(1, 9'h1c0);
      issue(3, 9'h17f);
   endtask

   task automatic t_timer();
      issue(4, 9'h038);
      run(8, 9'h008, 9'h008);
      issue(4, 9'h022);
      run(16, 9'h002, 9'h010);
      issue(4, 9'h00b);
      run(16, 9'h011, 9'h002);
      issue(5, 9'h07e);
   endtask

   task automatic t_pins();
      logic [8:0] hi = 9'h000;
      @(posedge clock_i);
      direction_i <= 3'b010;
      pin_latch_i <= 3'b100;
      issue(4, 9'h000);
      #1;
      check({general_pin_two_oe_o, general_pin_two_o, 1'b0, wake_enable_o,
             pullup_enable_o}, 9'h1b6);
      issue(4, 9'h0e0);
      #1;
      check({general_pin_two_oe_o, 2'b00, wake_enable_o, pullup_enable_o}, 9'h000);
      issue(5, 9'h081);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         #1;
         if (i > 3)
            hi = hi + {general_pin_two_oe_o, general_pin_two_o};
      end
      check(hi, 9'h00a);
      issue(5, 9'h080);
   endtask

   initial begin
      reset_n_i = 1'b0;
      general_pin_two_i = 1'b0;
      watchdog_base_i = 1'b0;
      direction_i = 3'b111;
      pin_latch_i = 3'b000;
      drive(0, 9'h000);
      do_reset();
      t_flow();
      t_timer();
      t_pins();
      do_reset();
      give_verdict();
   end

   // The run needs well under 1000 clocks
   initial begin
      #10000;
      miscompares++;
      give_verdict();
   end
endmodule // ccp_core_tb_top
